//--- logic/ctr_pkg.sv
// Constants shared by the channel telemetry readout block.
// Assumes a 250 MHz reference clock and 14-bit converter results.
package ctr_pkg;
    // Command codes of the read-only result registers
    localparam logic [7:0] CTR_CMD_CH1_CUR = 8'h30;
    localparam logic [7:0] CTR_CMD_CH1_VLT = 8'h32;
    localparam logic [7:0] CTR_CMD_CH2_CUR = 8'h34;
    localparam logic [7:0] CTR_CMD_CH2_VLT = 8'h36;
    localparam logic [7:0] CTR_CMD_CH3_CUR = 8'h38;
    localparam logic [7:0] CTR_CMD_CH3_VLT = 8'h3A;
    localparam logic [7:0] CTR_CMD_CH4_CUR = 8'h3C;
    localparam logic [7:0] CTR_CMD_CH4_VLT = 8'h3E;

    // Field layout: 14-bit result in bits 13..0, top two bits zero
    localparam int          CTR_RES_W      = 14;
    localparam int          CTR_LOW_LSB    = 0;
    localparam int          CTR_HIGH_LSB   = 8;
    localparam logic [13:0] CTR_RES_RESET  = 14'h0000;
    localparam logic [7:0]  CTR_UNMAPPED   = 8'h00;

    // Scaling, in nA and uV per count (for software reference)
    localparam int          CTR_CUR_LSB_NA = 89500;
    localparam int          CTR_CLS_LSB_NA = 8950;
    localparam int          CTR_VLT_LSB_UV = 3662;
    localparam int          CTR_NUM_CHAN   = 4;

    // Channel operating mode codes
    localparam logic [1:0]  CTR_MODE_OFF   = 2'h0;
    localparam logic [1:0]  CTR_MODE_DIAG  = 2'h1;
    localparam logic [1:0]  CTR_MODE_SEMI  = 2'h2;
    localparam logic [1:0]  CTR_MODE_AUTO  = 2'h3;

    // Refresh period of the powered current reading
    localparam int unsigned CTR_CLK_HZ        = 250000000;
    localparam int unsigned CTR_CONV_PERIOD_MS = 100;
    localparam int unsigned CTR_CONV_CYCLES   =
        32'(64'(CTR_CONV_PERIOD_MS) * 64'(CTR_CLK_HZ) / 64'd1000);

    // Read sequencer states
    typedef enum logic [0:0] {CTR_RD_LOW, CTR_RD_HIGH} ctr_rd_state_t;
endpackage

//--- logic/ctr_chan_if.sv
// Signals between the readout top and one channel current holder.
// Assumes both ends run on the same clock.
interface ctr_chan_if;
    logic        powered;
    logic        force_zero;
    logic        meas_en;
    logic        cur_valid;
    logic [13:0] cur_data;
    logic        cls_valid;
    logic [13:0] cls_data;
    logic        port_dis;
    logic [13:0] result;
    logic        is_class;

    modport top  (output powered, force_zero, meas_en, cur_valid, cur_data,
                  output cls_valid, cls_data, port_dis,
                  input  result, is_class);
    modport chan (input  powered, force_zero, meas_en, cur_valid, cur_data,
                  input  cls_valid, cls_data, port_dis,
                  output result, is_class);
endinterface

//--- logic/ctr_chan_current.sv
// Current result holder for one channel: powered and class readings.
// Assumes all controls come from logic on the same clock.
module ctr_chan_current
    import ctr_pkg::*;
(
    // Clock and reset
    input  wire logic i_ref_clk,
    input  wire logic i_rst_n,
    // Channel link
    ctr_chan_if.chan  ch
);
    logic [13:0] value;
    logic        hold_class;
    logic        ever_en;
    logic [13:0] next_value;
    logic        next_hold_class;
    logic        next_ever_en;

    // Next value: class reading wins over a powered reading and a disable
    always_comb begin
        next_value      = value;
        next_hold_class = hold_class;
        next_ever_en    = ever_en | ch.meas_en;
        if (ch.port_dis) begin
            next_value      = CTR_RES_RESET; // R11
            next_hold_class = 1'b0;
        end
        if (ch.cur_valid && (ch.powered || ch.meas_en)) begin
            next_value      = ch.cur_data; // R6 R9
            next_hold_class = 1'b0; // R11
        end
        if (ch.cls_valid) begin
            next_value      = ch.cls_data; // R11 R12
            next_hold_class = 1'b1; // R13
        end
    end

    // State registers
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            value      <= CTR_RES_RESET;
            hold_class <= 1'b0;
            ever_en    <= 1'b0;
        end else begin
            value      <= next_value;
            hold_class <= next_hold_class;
            ever_en    <= next_ever_en;
        end
    end

    // Forced-zero cases override the held value at the read side
    assign ch.result   = ch.force_zero ? CTR_RES_RESET : value; // R8
    assign ch.is_class = hold_class & ~ch.force_zero; // R13

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);

    property p_zero_forced;
        ch.force_zero |-> ch.result == 14'h0000;
    endproperty
    a_zero_forced: assert property (p_zero_forced) else $error("forced zero not shown"); // R8

    sequence s_class_done;
        ch.cls_valid ##1 1'b1;
    endsequence
    property p_class_loaded;
        s_class_done |-> hold_class && value == $past(ch.cls_data);
    endproperty
    a_class_loaded: assert property (p_class_loaded) else $error("class current not held"); // R11

    property p_class_held;
        (hold_class && !ch.cur_valid && !ch.port_dis && !ch.cls_valid)
            |=> $stable(value) && hold_class;
    endproperty
    a_class_held: assert property (p_class_held) else $error("class current lost"); // R11

    property p_disable_clears;
        (ch.port_dis && !ch.cls_valid && !ch.cur_valid) |=> !hold_class && value == 14'h0000;
    endproperty
    a_disable_clears: assert property (p_disable_clears) else $error("disable kept value"); // R11

    property p_manual_retain;
        (ever_en && !ch.force_zero && !ch.cur_valid && !ch.cls_valid && !ch.port_dis)
            ##1 !ch.force_zero |-> ch.result == $past(ch.result);
    endproperty
    a_manual_retain: assert property (p_manual_retain) else $error("last result not kept"); // R9
endmodule

//--- logic/ctr_readout.sv
// Channel telemetry readout: per-channel current and voltage results
// served as two-byte read-only registers to the command-byte engine.
// Assumes an I2C slave engine on the same clock delivers command codes
// and byte read requests, and converter logic delivers results.
//
// Overview of operation
// R1: Channel 3 and 4 currents readable at command codes 38h and 3Ch.
// R2: Channel 1 to 4 voltages readable at codes 32h, 36h, 3Ah, 3Eh.
// R3: Each result is two bytes, low byte first, then high byte.
// R4: Current holds 14 bits in 13..0; top two bits zero; resets zero.
// R5: Voltage holds 14 bits, eight low then six high; resets zero.
// R6: Powered channel current refreshes about every 100 ms.
// R7: Non-class current readings weigh 89.5 uA per count, about 1.46 A full scale.
// R8: Current reads zero when off, or semi-auto off without valid detection.
// R9: Diagnostic mode keeps the last result once measurement was enabled.
// R10: Four-pair ports still report each channel separately; host adds them.
// R11: Class current shown until a powered reading completes or port disabled.
// R12: Only the last classification finger's current is reported.
// R13: While class current is shown, each count weighs 8.95 uA.
// R14: Powered voltage weighs 3.662 mV per count, 60 V full scale.
// R15: Channel 1 and 2 currents readable at codes 30h and 34h.
// R16: Both bytes are captured together when the low byte is read.
module ctr_readout
    import ctr_pkg::*;
#(
    parameter int unsigned P_CONV_CYCLES = CTR_CONV_CYCLES
)(
    // Clock and reset
    input  wire logic                    i_ref_clk,
    input  wire logic                    i_rst_n,
    // Command and read byte port of the serial engine
    input  wire logic                    i_cmd_valid,
    input  wire logic [7:0]              i_cmd_code,
    input  wire logic                    i_rd_req,
    output logic      [7:0]              o_rd_data,
    output logic                         o_rd_valid,
    // Channel status
    input  wire logic [3:0][1:0]         i_chan_mode,
    input  wire logic [3:0]              i_chan_powered,
    input  wire logic [3:0]              i_det_cls_en,
    input  wire logic [3:0]              i_det_good,
    input  wire logic [3:0]              i_meas_en,
    input  wire logic [3:0]              i_port_dis,
    // Converter results
    input  wire logic [3:0]              i_cur_valid,
    input  wire logic [3:0][13:0]        i_cur_data,
    input  wire logic [3:0]              i_cls_valid,
    input  wire logic [3:0]              i_cls_last,
    input  wire logic [3:0][13:0]        i_cls_data,
    input  wire logic [3:0]              i_volt_valid,
    input  wire logic [3:0][13:0]        i_volt_data,
    // Conversion requests and scale indication
    output logic      [3:0]              o_conv_req,
    output logic      [3:0]              o_cur_is_class
);
    ctr_rd_state_t     rd_state;
    ctr_rd_state_t     next_rd_state;
    logic [7:0]        cmd;
    logic [7:0]        next_cmd;
    logic [15:0]       snap;
    logic [15:0]       next_snap;
    logic [7:0]        next_rd_data;
    logic              next_rd_valid;
    logic [3:0][13:0]  volt;
    logic [3:0][13:0]  next_volt;
    logic [31:0]       tick_cnt;
    logic [31:0]       next_tick_cnt;
    logic              tick;
    logic [3:0]        next_conv_req;
    logic [3:0][13:0]  cur_res;
    logic [3:0]        cur_cls;
    logic [16:0]       sel;

    // Register word for a command code: bit 16 flags a mapped code
    function automatic logic [16:0] reg_word(input logic [7:0] code,
                                             input logic [3:0][13:0] cur,
                                             input logic [3:0][13:0] vlt);
        logic [16:0] w;
        w = 17'h00000;
        case (code)
            CTR_CMD_CH1_CUR: w = {1'b1, 2'b00, cur[0]}; // R15 R4
            CTR_CMD_CH2_CUR: w = {1'b1, 2'b00, cur[1]}; // R15 R4
            CTR_CMD_CH3_CUR: w = {1'b1, 2'b00, cur[2]}; // R1 R4
            CTR_CMD_CH4_CUR: w = {1'b1, 2'b00, cur[3]}; // R1 R4
            CTR_CMD_CH1_VLT: w = {1'b1, 2'b00, vlt[0]}; // R2 R5
            CTR_CMD_CH2_VLT: w = {1'b1, 2'b00, vlt[1]}; // R2 R5
            CTR_CMD_CH3_VLT: w = {1'b1, 2'b00, vlt[2]}; // R2 R5
            CTR_CMD_CH4_VLT: w = {1'b1, 2'b00, vlt[3]}; // R2 R5
            default:         w = 17'h00000;
        endcase
        return w;
    endfunction

    // One current holder per channel; channels stay separate for 4-pair ports
    ctr_chan_if chan_if [CTR_NUM_CHAN] ();
    for (genvar k = 0; k < CTR_NUM_CHAN; k++) begin : g_chan
        assign chan_if[k].powered    = i_chan_powered[k];
        assign chan_if[k].force_zero = (i_chan_mode[k] == CTR_MODE_OFF) ||
                                       ((i_chan_mode[k] == CTR_MODE_SEMI) &&
                                        !i_chan_powered[k] &&
                                        (!i_det_cls_en[k] || !i_det_good[k])); // R8
        assign chan_if[k].meas_en    = i_meas_en[k] &&
                                       (i_chan_mode[k] == CTR_MODE_DIAG); // R9
        assign chan_if[k].cur_valid  = i_cur_valid[k];
        assign chan_if[k].cur_data   = i_cur_data[k];
        assign chan_if[k].cls_valid  = i_cls_valid[k] && i_cls_last[k]; // R12
        assign chan_if[k].cls_data   = i_cls_data[k];
        assign chan_if[k].port_dis   = i_port_dis[k];
        assign cur_res[k]            = chan_if[k].result; // R10
        assign cur_cls[k]            = chan_if[k].is_class;

        ctr_chan_current u_chan (
            .i_ref_clk (i_ref_clk),
            .i_rst_n   (i_rst_n),
            .ch        (chan_if[k])
        );
    end

    // Class readings use the finer scale; flag it to the host side
    assign o_cur_is_class = cur_cls; // R13 R7

    // Refresh divider: one-cycle enable every conversion period
    assign tick = (tick_cnt == P_CONV_CYCLES - 32'd1);
    always_comb begin
        next_tick_cnt = tick ? 32'h00000000 : 32'(tick_cnt + 32'h00000001);
        next_conv_req = tick ? i_chan_powered : 4'h0; // R6
    end

    // Voltage results taken only while powered
    always_comb begin
        next_volt = volt;
        for (int k = 0; k < CTR_NUM_CHAN; k++) begin
            if (i_volt_valid[k] && i_chan_powered[k]) begin
                next_volt[k] = i_volt_data[k]; // R14
            end
        end
    end

    // Read sequencer: low byte captures the whole word, high byte follows
    assign sel = reg_word(cmd, cur_res, volt);
    always_comb begin
        next_cmd      = cmd;
        next_rd_state = rd_state;
        next_snap     = snap;
        next_rd_data  = o_rd_data;
        next_rd_valid = 1'b0;
        if (i_cmd_valid) begin
            next_cmd      = i_cmd_code;
            next_rd_state = CTR_RD_LOW;
        end else if (i_rd_req) begin
            next_rd_valid = 1'b1;
            unique case (rd_state)
                CTR_RD_LOW: begin
                    next_snap     = sel[15:0]; // R16
                    next_rd_data  = sel[CTR_LOW_LSB +: 8]; // R3
                    next_rd_state = CTR_RD_HIGH;
                end
                CTR_RD_HIGH: begin
                    next_rd_data  = snap[CTR_HIGH_LSB +: 8]; // R3 R16
                    next_rd_state = CTR_RD_LOW;
                end
            endcase
        end
    end

    // State registers
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            cmd        <= CTR_UNMAPPED;
            rd_state   <= CTR_RD_LOW;
            snap       <= 16'h0000;
            o_rd_data  <= 8'h00;
            o_rd_valid <= 1'b0;
            volt       <= '0;
            tick_cnt   <= 32'h00000000;
            o_conv_req <= 4'h0;
        end else begin
            cmd        <= next_cmd;
            rd_state   <= next_rd_state;
            snap       <= next_snap;
            o_rd_data  <= next_rd_data;
            o_rd_valid <= next_rd_valid;
            volt       <= next_volt;
            tick_cnt   <= next_tick_cnt;
            o_conv_req <= next_conv_req;
        end
    end

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);

    sequence s_low_read;
        !i_cmd_valid && i_rd_req && rd_state == CTR_RD_LOW;
    endsequence
    sequence s_high_read;
        !i_cmd_valid && i_rd_req && rd_state == CTR_RD_HIGH;
    endsequence

    property p_low_first;
        s_low_read |=> o_rd_valid && o_rd_data == $past(sel[7:0]);
    endproperty
    a_low_first: assert property (p_low_first) else $error("low byte wrong"); // R3

    property p_high_second;
        s_low_read ##1 s_high_read |=> o_rd_valid && o_rd_data == $past(snap[15:8], 1);
    endproperty
    a_high_second: assert property (p_high_second) else $error("high byte wrong"); // R3

    property p_pair_atomic;
        s_low_read |=> snap == $past(sel[15:0]);
    endproperty
    a_pair_atomic: assert property (p_pair_atomic) else $error("word not captured"); // R16

    property p_top_bits_zero;
        s_high_read |=> o_rd_data[7:6] == 2'b00;
    endproperty
    a_top_bits_zero: assert property (p_top_bits_zero) else $error("top bits set"); // R4

    property p_ch3_current;
        (s_low_read and cmd == 8'h38) |=> snap == {2'b00, $past(cur_res[2])};
    endproperty
    a_ch3_current: assert property (p_ch3_current) else $error("code 38h wrong"); // R1

    property p_ch1_voltage;
        (s_low_read and cmd == 8'h32) |=> snap == {2'b00, $past(volt[0])};
    endproperty
    a_ch1_voltage: assert property (p_ch1_voltage) else $error("code 32h wrong"); // R2

    property p_volt_update;
        i_volt_valid[1] && i_chan_powered[1] |=> volt[1] == $past(i_volt_data[1]);
    endproperty
    a_volt_update: assert property (p_volt_update) else $error("voltage not taken"); // R14

    property p_unmapped_zero;
        (s_low_read and !sel[16]) |=> o_rd_data == 8'h00;
    endproperty
    a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped not zero"); // R5

    property p_refresh_tick;
        tick |=> o_conv_req == $past(i_chan_powered) ##1 o_conv_req == 4'h0;
    endproperty
    a_refresh_tick: assert property (p_refresh_tick) else $error("refresh request wrong"); // R6

    // Remaining map entries: each code captures its own channel's word
    property p_ch1_current;
        (s_low_read and cmd == CTR_CMD_CH1_CUR) |=> snap == {2'b00, $past(cur_res[0])};
    endproperty
    a_ch1_current: assert property (p_ch1_current) else $error("code 30h wrong"); // R15

    property p_ch2_current;
        (s_low_read and cmd == CTR_CMD_CH2_CUR) |=> snap == {2'b00, $past(cur_res[1])};
    endproperty
    a_ch2_current: assert property (p_ch2_current) else $error("code 34h wrong"); // R15

    property p_ch4_current;
        (s_low_read and cmd == CTR_CMD_CH4_CUR) |=> snap == {2'b00, $past(cur_res[3])};
    endproperty
    a_ch4_current: assert property (p_ch4_current) else $error("code 3Ch wrong"); // R1

    property p_ch2_voltage;
        (s_low_read and cmd == CTR_CMD_CH2_VLT) |=> snap == {2'b00, $past(volt[1])};
    endproperty
    a_ch2_voltage: assert property (p_ch2_voltage) else $error("code 36h wrong"); // R2

    property p_ch3_voltage;
        (s_low_read and cmd == CTR_CMD_CH3_VLT) |=> snap == {2'b00, $past(volt[2])};
    endproperty
    a_ch3_voltage: assert property (p_ch3_voltage) else $error("code 3Ah wrong"); // R2

    property p_ch4_voltage;
        (s_low_read and cmd == CTR_CMD_CH4_VLT) |=> snap == {2'b00, $past(volt[3])};
    endproperty
    a_ch4_voltage: assert property (p_ch4_voltage) else $error("code 3Eh wrong"); // R2

    // A command edge restarts the byte order and answers no byte
    property p_cmd_restart;
        i_cmd_valid |=> rd_state == CTR_RD_LOW && !o_rd_valid;
    endproperty
    a_cmd_restart: assert property (p_cmd_restart) else $error("order not restarted"); // R3

    // The read byte stands until the next byte read
    property p_data_stands;
        !(i_rd_req && !i_cmd_valid) |=> $stable(o_rd_data) && !o_rd_valid;
    endproperty
    a_data_stands: assert property (p_data_stands) else $error("read byte moved"); // R3

    // An unpowered channel keeps its last voltage result
    property p_volt_keep;
        !i_chan_powered[2] |=> $stable(volt[2]);
    endproperty
    a_volt_keep: assert property (p_volt_keep) else $error("voltage changed unpowered"); // R14

    // No refresh request between divider ticks
    property p_refresh_quiet;
        !tick |=> o_conv_req == 4'h0;
    endproperty
    a_refresh_quiet: assert property (p_refresh_quiet) else $error("stray refresh request"); // R6

    // A channel in off mode reads a zero current low byte
    property p_off_reads_zero;
        (s_low_read and cmd == CTR_CMD_CH4_CUR and i_chan_mode[3] == CTR_MODE_OFF)
            |=> o_rd_data == 8'h00;
    endproperty
    a_off_reads_zero: assert property (p_off_reads_zero) else $error("off channel not zero"); // R8
endmodule

//--- tb/ctr_host_model.sv
// Host model: sends one command byte, then reads two bytes back to back.
// Assumes the readout answers each byte read exactly one cycle later.
module ctr_host_model
    import ctr_pkg::*;
(
    // Clock and bench control
    input  wire logic        i_ref_clk,
    input  wire logic        i_start,
    input  wire logic [7:0]  i_code,
    // Read byte port of the readout
    input  wire logic [7:0]  i_rd_data,
    input  wire logic        i_rd_valid,
    output logic             o_cmd_valid,
    output logic [7:0]       o_cmd_code,
    output logic             o_rd_req,
    // Assembled result
    output logic [15:0]      o_word,
    output logic             o_done
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] st;
    logic [1:0] nb;

    // Idle values at time zero
    initial begin
        st = 3'h0;
        nb = 2'h0;
        o_cmd_valid = 1'b0;
        o_cmd_code = 8'h00;
        o_rd_req = 1'b0;
        o_word = 16'h0000;
        o_done = 1'b0;
    end

    // Command, two reads, then wait for both bytes
    always @(posedge i_ref_clk) begin
        if (i_rd_valid) begin
            if (nb == 2'h0) o_word[7:0] <= i_rd_data;
            else o_word[15:8] <= i_rd_data;
            nb <= nb + 2'h1;
        end
        case (st)
            3'h0: if (i_start) begin
                o_cmd_valid <= 1'b1;
                o_cmd_code <= i_code;
                o_done <= 1'b0;
                nb <= 2'h0;
                st <= 3'h1;
            end
            3'h1: begin
                o_cmd_valid <= 1'b0;
                o_cmd_code <= ~o_cmd_code; // Code is not held once taken
                o_rd_req <= 1'b1;
                st <= 3'h2;
            end
            3'h2: st <= 3'h3; // Second read follows at once
            3'h3: begin
                o_rd_req <= 1'b0;
                st <= 3'h4;
            end
            default: if (nb == 2'h2) begin
                o_done <= 1'b1;
                st <= 3'h0;
            end
        endcase
    end
endmodule

//--- tb/tb_channel_telemetry_readout.sv
// Self-checking bench for the telemetry readout block.
// Assumes the host model above and a shortened refresh period of 16.
module tb_channel_telemetry_readout
    import ctr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] CUR [4] = '{CTR_CMD_CH1_CUR, CTR_CMD_CH2_CUR,
                                       CTR_CMD_CH3_CUR, CTR_CMD_CH4_CUR};
    localparam logic [7:0] VLT [4] = '{CTR_CMD_CH1_VLT, CTR_CMD_CH2_VLT,
                                       CTR_CMD_CH3_VLT, CTR_CMD_CH4_VLT};
    logic clk = 1'b0, rst_n = 1'b0, start = 1'b0, done, cmd_valid, rd_req, rd_valid;
    logic [7:0] code = 8'h00, cmd_code, rd_data;
    logic [15:0] word;
    logic [3:0][1:0] mode = '0;
    logic [3:0] pwr = '0, dcen = '0, dgood = '0, meas = '0, pdis = '0, curv = '0;
    logic [3:0] clsv = '0, clsl = '0, vv = '0, conv_req, is_class;
    logic [3:0][13:0] curd = '0, clsd = '0, vd = '0;
    int miscompares = 0, checks = 0, n;

    ctr_readout #(.P_CONV_CYCLES(16)) u_dut (.i_ref_clk(clk), .i_rst_n(rst_n),
        .i_cmd_valid(cmd_valid), .i_cmd_code(cmd_code), .i_rd_req(rd_req),
        .o_rd_data(rd_data), .o_rd_valid(rd_valid), .i_chan_mode(mode),
        .i_chan_powered(pwr), .i_det_cls_en(dcen), .i_det_good(dgood),
        .i_meas_en(meas), .i_port_dis(pdis), .i_cur_valid(curv), .i_cur_data(curd),
        .i_cls_valid(clsv), .i_cls_last(clsl), .i_cls_data(clsd), .i_volt_valid(vv),
        .i_volt_data(vd), .o_conv_req(conv_req), .o_cur_is_class(is_class));
    ctr_host_model u_host (.i_ref_clk(clk), .i_start(start), .i_code(code),
        .i_rd_data(rd_data), .i_rd_valid(rd_valid), .o_cmd_valid(cmd_valid),
        .o_cmd_code(cmd_code), .o_rd_req(rd_req), .o_word(word), .o_done(done));

    // 250 MHz clock
    initial begin
        forever #2 clk = ~clk;
    end

    task automatic close_out();
        if (miscompares == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %4h expected %4h", $time, got, exp);
        end
    endtask

    // One register read through the host model
    task automatic rd(input logic [7:0] c, input logic [15:0] exp);
        int k;
        k = 0;
        @(posedge clk);
        start <= 1'b1;
        code <= c;
        @(posedge clk);
        start <= 1'b0;
        @(posedge clk);
        #1;
        while (done !== 1'b1 && k < 20) begin
            @(posedge clk);
            #1;
            k++;
        end
        chk({15'h0000, done}, 16'h0001);
        chk(word, exp);
    endtask

    // One-cycle event: bit0 current, bit1 class, bit2 last finger, bit3 volt, bit4 disable
    task automatic pulse(input int ch, input logic [4:0] k, input logic [13:0] d);
        @(posedge clk);
        curd[ch] <= d;
        clsd[ch] <= d;
        vd[ch] <= d;
        {pdis[ch], vv[ch], clsl[ch], clsv[ch], curv[ch]} <= k;
        @(posedge clk);
        {pdis, vv, clsl, clsv, curv} <= '0;
    endtask

    // Watchdog
    initial begin
        repeat (5000) @(posedge clk);
        miscompares++;
        close_out();
    end

    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            rd(CUR[i], 16'h0000);
            rd(VLT[i], 16'h0000);
        end
        rd(8'h31, 16'h0000);
        @(posedge clk);
        mode <= {4{CTR_MODE_AUTO}};
        pwr <= 4'hF;
        // Refresh request spacing while powered
        n = 0;
        do begin @(posedge clk); #1; n++; end while (conv_req === 4'h0 && n < 40);
        chk({12'h000, conv_req}, 16'h000F);
        n = 0;
        do begin @(posedge clk); #1; n++; end while (conv_req === 4'h0 && n < 40);
        chk(16'(n), 16'h0010);
        for (int i = 0; i < 4; i++) begin
            pulse(i, 5'h08, 14'h3FFF - 14'(i));
            rd(VLT[i], 16'h3FFF - 16'(i));
            pulse(i, 5'h01, 14'h2A50 + 14'(i));
            rd(CUR[i], 16'h2A50 + 16'(i));
        end
        chk({12'h000, is_class}, 16'h0000);
        // Class current on channel 3: only the last finger counts
        pulse(2, 5'h02, 14'h0111);
        rd(CUR[2], 16'h2A52);
        pulse(2, 5'h06, 14'h0123);
        rd(CUR[2], 16'h0123);
        chk({12'h000, is_class}, 16'h0004);
        pulse(2, 5'h01, 14'h1357);
        rd(CUR[2], 16'h1357);
        chk({12'h000, is_class}, 16'h0000);
        pulse(2, 5'h06, 14'h0222);
        pulse(2, 5'h10, 14'h0000);
        rd(CUR[2], 16'h0000);
        // Forced zero cases on channel 4
        @(posedge clk);
        mode[3] <= CTR_MODE_OFF;
        rd(CUR[3], 16'h0000);
        @(posedge clk);
        mode[3] <= CTR_MODE_SEMI;
        pwr[3] <= 1'b0;
        rd(CUR[3], 16'h0000);
        @(posedge clk);
        dcen[3] <= 1'b1;
        rd(CUR[3], 16'h0000);
        @(posedge clk);
        dgood[3] <= 1'b1;
        rd(CUR[3], 16'h2A53);
        // Diagnostic mode keeps the last measurement
        @(posedge clk);
        mode[0] <= CTR_MODE_DIAG;
        pwr[0] <= 1'b0;
        meas[0] <= 1'b1;
        pulse(0, 5'h01, 14'h0777);
        @(posedge clk);
        meas[0] <= 1'b0;
        rd(CUR[0], 16'h0777);
        close_out();
    end
endmodule
